// file: dv/quad_conv_update_chk.sv
// Assertion checker for the quad converter update logic
`timescale 1ns/1ps
module quad_conv_update_chk
    import quad_conv_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Serial pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    input  wire logic        sda_out,
    input  wire logic        sda_oe,
    // Straps and strobe
    input  wire logic [1:0]  addr_sel_in,
    input  wire logic        ext_addr_bit_hi,
    input  wire logic        ext_addr_bit_lo,
    input  wire logic        async_load_strobe,
    // Converter registers
    input  wire logic [11:0] output_reg_a,
    input  wire logic [11:0] output_reg_b,
    input  wire logic [11:0] output_reg_c,
    input  wire logic [11:0] output_reg_d
);
    // ********
    // Helper logic
    // ********
    logic [47:0] outs;
    logic        oe_d1_reg;
    logic        oe_d2_reg;
    logic        stb_d_reg;
    logic [3:0]  stb_cnt_reg;
    // Flat view of the four converter registers
    assign outs = {output_reg_a, output_reg_b, output_reg_c, output_reg_d};
    // Acknowledge history, to place the commit moment
    always_ff @(posedge clk_sys) begin
        oe_d1_reg <= sda_oe;
        oe_d2_reg <= oe_d1_reg;
    end
    // Cycles since strobe rise; saturates so it never wraps back
    always_ff @(posedge clk_sys) begin
        stb_d_reg <= async_load_strobe;
        if (rst) stb_cnt_reg <= 4'hF;
        else if (async_load_strobe && !stb_d_reg) stb_cnt_reg <= 4'h0;
        else if (stb_cnt_reg != 4'hF) stb_cnt_reg <= stb_cnt_reg + 4'h1;
    end
    // ********
    // Assertions
    // ********
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Acknowledge rises, holds a whole clock, then lets go
    sequence s_ack_rise;
        $rose(sda_oe);
    endsequence
    sequence s_ack_span;
        sda_oe [*8] ##[1:16] !sda_oe;
    endsequence
    a_drive_low: assert property (sda_out == 1'b0)
        else $error("data drive value not low");
    a_reset_clear: assert property (disable iff (1'b0)
        rst |=> outs == 48'h0 && !sda_oe)
        else $error("registers not clear after reset");
    a_ack_low_clock: assert property (s_ack_rise |-> !scl_in)
        else $error("acknowledge raised while clock high");
    a_ack_span: assert property (s_ack_rise |-> s_ack_span)
        else $error("acknowledge not held for one clock");
    a_ack_release: assert property ($fell(sda_oe) |-> !scl_in)
        else $error("acknowledge released while clock high");
    a_oe_steady_high: assert property (
        scl_in && $past(scl_in) |-> $stable(sda_oe))
        else $error("data drive moved while clock high");
    a_update_moment: assert property (outs != $past(outs) |->
        (oe_d1_reg && !sda_oe) || (oe_d2_reg && !oe_d1_reg) ||
        stb_cnt_reg inside {[4'h1:4'hA]})
        else $error("converter update outside commit or strobe");
    a_pd_zero_data: assert property (
        (|output_reg_a[11:10] -> ~|output_reg_a[9:0]) &&
        (|output_reg_b[11:10] -> ~|output_reg_b[9:0]) &&
        (|output_reg_c[11:10] -> ~|output_reg_c[9:0]) &&
        (|output_reg_d[11:10] -> ~|output_reg_d[9:0]))
        else $error("power-down register carries data bits");
endmodule
bind quad_conv_update quad_conv_update_chk i_quad_conv_update_chk (
    .clk_sys(clk_sys), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel_in(addr_sel_in),
    .ext_addr_bit_hi(ext_addr_bit_hi), .ext_addr_bit_lo(ext_addr_bit_lo),
    .async_load_strobe(async_load_strobe), .output_reg_a(output_reg_a),
    .output_reg_b(output_reg_b), .output_reg_c(output_reg_c),
    .output_reg_d(output_reg_d)
);

// file: dv/quad_conv_update_tb_top.sv
// Self-checking bench for the quad converter update logic
`timescale 1ns/1ps
module quad_conv_update_tb_top import quad_conv_pkg::*;;
    localparam logic [6:0] LA = {SLAVE_ADDR_FIXED, 2'h1};
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        strobe = 1'b0;
    logic        snap = 1'b0;
    logic [1:0]  addr_sel = 2'h1;
    logic        ext_hi = 1'b1;
    logic        ext_lo = 1'b0;
    wire         scl;
    wire         sda_low;
    wire         sda;
    logic        sda_out;
    logic        sda_oe;
    logic [11:0] out_a;
    logic [11:0] out_b;
    logic [11:0] out_c;
    logic [11:0] out_d;
    logic [11:0] st[4] = '{4{12'h000}};
    logic [11:0] ex[4] = '{4{12'h000}};
    logic [47:0] note_q[$];
    logic [31:0] seed = 32'h6AD8;
    int          num_errors = 0;
    int          checks_done = 0;
    int          step = 0;
    // ********
    // Clock, wire and instances
    // ********
    always #12.5 clk_sys = ~clk_sys;
    assign sda = !(sda_low || sda_oe);
    quad_conv_update i_quad_conv_update (
        .clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel_in(addr_sel),
        .ext_addr_bit_hi(ext_hi), .ext_addr_bit_lo(ext_lo),
        .async_load_strobe(strobe), .output_reg_a(out_a),
        .output_reg_b(out_b), .output_reg_c(out_c), .output_reg_d(out_d)
    );
    serial_master_model i_serial_master_model (
        .clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_low(sda_low)
    );
    // ********
    // Checking
    // ********
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic chk(input string nm, input logic [47:0] e,
                       input logic [47:0] g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Oldest note taken whenever a settled result is flagged
    always @(posedge clk_sys) begin
        if (snap === 1'b1) begin
            chk("converter registers", note_q.pop_front(),
                {out_a, out_b, out_c, out_d});
        end
    end
    // Late enough that any commit has landed
    task automatic note();
        repeat (16) @(posedge clk_sys);
        note_q.push_back({ex[0], ex[1], ex[2], ex[3]});
        snap <= 1'b1;
        @(posedge clk_sys);
        snap <= 1'b0;
        step++;
        $display("test step %0d done", step);
    endtask
    // One frame of n word pairs; the model tracks both register sets
    task automatic wr(input logic [6:0] ad, input logic [7:0] cmd,
                      input int n);
        logic        hit;
        logic        ack;
        logic        a_ok;
        logic [7:0]  hi;
        logic [7:0]  lo;
        logic [11:0] w;
        logic [1:0]  md;
        int          s;
        md = cmd[UPD_MODE_HI_POS:UPD_MODE_LO_POS];
        s = cmd[CHAN_SEL_HI_POS:CHAN_SEL_LO_POS];
        a_ok = ad == LA || ad == BCAST_ADDR;
        hit = md == MODE_BROADCAST || ad == LA && cmd[7:6] == {ext_hi, ext_lo};
        i_serial_master_model.open_frame(ad, cmd, ack);
        chk("address ack", a_ok, ack);
        for (int k = 0; k < n; k++) begin
            seed = lfsr(seed);
            hi = cmd[0] ? {seed[1:0] | 2'h1, 6'h00} : seed[9:2];
            lo = cmd[0] ? 8'h00 : seed[17:10];
            w = cmd[0] ? {hi[7:6], 10'h000} : {2'h0, hi, lo[7:6]};
            i_serial_master_model.send_byte(hi, ack);
            chk("high byte ack", a_ok, ack);
            i_serial_master_model.send_byte(lo, ack);
            chk("low byte ack", a_ok, ack);
            for (int c = 0; c < 4 && hit; c++) begin
                if (md == MODE_BROADCAST ? cmd[2] : c == s) st[c] = w;
                if (md[1] || md == MODE_DIRECT && c == s) ex[c] = st[c];
            end
        end
        i_serial_master_model.stop();
        note();
    endtask
    // Strobe is pulsed only once staging holds what is wanted
    task automatic pulse();
        strobe <= 1'b1;
        repeat (8) @(posedge clk_sys);
        strobe <= 1'b0;
        ex = st;
        note();
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ********
    // Scenarios
    // ********
    initial begin
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (8) @(posedge clk_sys);
        note();
        for (int c = 0; c < 4; c++) begin
            wr(LA, {4'h8, 1'b0, c[1:0], 1'b0}, 1);
        end
        pulse();
        wr(LA, {2'h2, MODE_DIRECT, 1'b0, 2'h3, 1'b0}, 2);
        wr(LA, {2'h2, MODE_SYNC_ALL, 1'b0, 2'h1, 1'b0}, 1);
        wr(LA, {2'h2, MODE_STAGE_ONLY, 1'b0, 2'h2, 1'b1}, 1);
        wr(LA, {2'h2, MODE_DIRECT, 1'b0, 2'h0, 1'b1}, 1);
        wr(LA, {2'h1, MODE_DIRECT, 1'b0, 2'h1, 1'b0}, 1);
        wr(LA, {2'h0, MODE_BROADCAST, 1'b0, 2'h1, 1'b0}, 1);
        wr(BCAST_ADDR, {2'h0, MODE_BROADCAST, 1'b0, 2'h2, 1'b0}, 1);
        wr(BCAST_ADDR, {2'h0, MODE_BROADCAST, 1'b0, 2'h2, 1'b1}, 1);
        wr(BCAST_ADDR, {2'h2, MODE_DIRECT, 1'b0, 2'h0, 1'b0}, 1);
        wr(7'h4F, {2'h2, MODE_DIRECT, 1'b0, 2'h1, 1'b0}, 1);
        final_report();
    end
    // Watchdog for a hung run
    initial begin
        repeat (20000) @(posedge clk_sys);
        num_errors++;
        $display("ERROR watchdog expected finish seen timeout");
        final_report();
    end
endmodule

// file: dv/serial_master_model.sv
// Behavioural two-wire bus master for the converter's serial pins
`timescale 1ns/1ps
module serial_master_model #(
    // Six clocks low and two high give the 200 ns link period
    parameter int LOW  = 6,
    parameter int HIGH = 2
) (
    // Clock
    input  wire logic clk_sys,
    // Resolved data wire, pulled up
    input  wire logic sda,
    // Master drive
    output logic      scl,
    output logic      sda_low
);
    // Idle bus; the clock stands still outside frames
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Low phase outlasts the slave's five-clock acknowledge turnaround,
    // so data only moves once the slave has let go of the line
    task automatic clk_bit(input logic b, output logic seen);
        tick(LOW - 1);
        sda_low <= !b;
        tick(1);
        scl <= 1'b1;
        tick(HIGH - 1);
        seen = sda;
        tick(1);
        scl <= 1'b0;
    endtask
    // Start, or repeated start when the clock is low
    task automatic start();
        if (!scl) begin
            tick(LOW - 1);
            sda_low <= 1'b0;
            tick(1);
            scl <= 1'b1;
            tick(LOW);
        end
        sda_low <= 1'b1;
        tick(LOW);
        scl <= 1'b0;
    endtask
    task automatic stop();
        tick(LOW - 1);
        sda_low <= 1'b1;
        tick(1);
        scl <= 1'b1;
        tick(LOW);
        sda_low <= 1'b0;
        tick(2 * LOW);
    endtask
    // Highest bit first, then the acknowledge clock
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
        clk_bit(1'b1, s);
        ack = !s;
    endtask
    // Each write opens with the address in write direction, then command
    task automatic open_frame(input logic [6:0] ad, input logic [7:0] cmd,
                              output logic ack);
        logic a1;
        logic a2;
        start();
        send_byte({ad, 1'b0}, a1);
        send_byte(cmd, a2);
        ack = a1 && a2;
    endtask
endmodule

// file: hw/quad_conv_pkg.sv
// Shared constants of the quad converter command and update logic
package quad_conv_pkg;

    // ********************************************************
    // Bus addressing
    // ********************************************************
    // Fixed upper five bits of the local 7-bit slave address
    localparam logic [4:0] SLAVE_ADDR_FIXED = 5'h13;
    // Broadcast slave address shared by all devices on the bus
    localparam logic [6:0] BCAST_ADDR       = 7'h48;
    // Bits in one byte before the acknowledge slot
    localparam logic [3:0] BITS_PER_BYTE    = 4'h8;

    // ********************************************************
    // Command byte field positions
    // ********************************************************
    localparam int EXT_ADDR_HI_POS  = 7;
    localparam int EXT_ADDR_LO_POS  = 6;
    localparam int UPD_MODE_HI_POS  = 5;
    localparam int UPD_MODE_LO_POS  = 4;
    localparam int CHAN_SEL_HI_POS  = 2;
    localparam int CHAN_SEL_LO_POS  = 1;
    localparam int PD_FLAG_POS      = 0;

    // ********************************************************
    // Update modes
    // ********************************************************
    localparam logic [1:0] MODE_STAGE_ONLY = 2'h0;
    localparam logic [1:0] MODE_DIRECT     = 2'h1;
    localparam logic [1:0] MODE_SYNC_ALL   = 2'h2;
    localparam logic [1:0] MODE_BROADCAST  = 2'h3;

    // ********************************************************
    // Register widths and reset values
    // ********************************************************
    localparam int          CHAN_REG_W    = 12;
    localparam int          CONV_DATA_W   = 10;
    localparam logic [11:0] CHAN_REG_RST  = 12'h000;
    localparam logic [7:0]  BYTE_RST      = 8'h00;

    // Serial protocol states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CTRL,
        ST_HIGH,
        ST_LOW,
        ST_IGNORE
    } bus_state_type;

endpackage

// file: hw/quad_conv_update.sv
// Serial slave, command decode and channel register update logic
//
// Function
// - Mode 00, no power-down: load only selected staging register, outputs hold.
// - Mode 10: write selected staging, load all four output registers at once.
// - Mode 11, select high clear: all outputs take their staging values.
// - Mode 11, select high set, no power-down: all channels take new data.
// - Mode 11, select high set, power-down: all channels take power-down code.
// - First data byte is upper eight bits of the 10-bit code.
// - Power-down flag set: top two bits of first byte are power-down code.
// - Lowest two code bits come from bits 7 and 6 of second byte.
// - Register updates happen at falling clock ending the low byte acknowledge.
// - All channel registers clear to zero at reset, so readback is zero.
// - Rising load strobe copies all staging registers into output registers.
// - Each channel has a 12-bit staging register: two power-down, ten data.
// - Each channel has a 12-bit output register, driving output immediately.
// - Received command byte is held and steers following data bytes.
// - Device acts as 7-bit addressed slave receiver on the two-wire bus.
// - Outside broadcast, act only when extended address bits match the pins.
// - Mode 01: write selected staging and output registers together.
// - Without power-down, keep taking high/low byte pairs until stop or start.
`timescale 1ns/1ps

module quad_conv_update
    import quad_conv_pkg::*;
#(
    parameter int SYNC_W = 7
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Two-wire serial pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    // Address straps
    input  wire logic [1:0]  addr_sel_in,
    input  wire logic        ext_addr_bit_hi,
    input  wire logic        ext_addr_bit_lo,
    // Asynchronous load strobe
    input  wire logic        async_load_strobe,
    // Converter register contents
    output logic [11:0]      output_reg_a,
    output logic [11:0]      output_reg_b,
    output logic [11:0]      output_reg_c,
    output logic [11:0]      output_reg_d
);

    // ********************************************************
    // Input synchronisers and glitch filter
    // ********************************************************
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [SYNC_W-1:0] sync3_reg;
    logic [SYNC_W-1:0] filt_reg;
    logic [SYNC_W-1:0] filt_next;
    logic [SYNC_W-1:0] prev_reg;
    logic [SYNC_W-1:0] pins_raw;

    assign pins_raw = {addr_sel_in, ext_addr_bit_hi, ext_addr_bit_lo,
                       async_load_strobe, sda_in, scl_in};

    // A bit only moves once the second and third stages agree
    assign filt_next = (sync2_reg & sync3_reg)
                     | (filt_reg & (sync2_reg | sync3_reg));

    // Three-stage chain, filtered level and its previous value
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            // Whole chain starts high, the bus idle level, so the release of
            // reset shows no false start, stop or clock edge and no strobe rise
            sync1_reg <= '1;
            sync2_reg <= '1;
            sync3_reg <= '1;
            filt_reg  <= '1;
            prev_reg  <= '1;
        end else begin
            sync1_reg <= pins_raw;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg  <= filt_next;
            prev_reg  <= filt_reg;
        end
    end

    // Filtering costs four clocks; the link's low phase must outlast
    // five clocks so the acknowledge is gone before data moves
    // Edge and condition detection on filtered levels
    logic       scl_rise;
    logic       scl_fall;
    logic       start_cond;
    logic       stop_cond;
    logic       strobe_rise;
    logic [1:0] ext_pins;
    logic [1:0] addr_pins;

    assign scl_rise    = filt_reg[0] & ~prev_reg[0];
    assign scl_fall    = ~filt_reg[0] & prev_reg[0];
    // Data moving while the clock is high marks start or stop
    assign start_cond  = filt_reg[0] & prev_reg[0]
                       & ~filt_reg[1] & prev_reg[1];
    assign stop_cond   = filt_reg[0] & prev_reg[0]
                       & filt_reg[1] & ~prev_reg[1];
    assign strobe_rise = filt_reg[2] & ~prev_reg[2];
    assign ext_pins    = filt_reg[4:3];
    assign addr_pins   = filt_reg[6:5];

    // ********************************************************
    // Serial byte engine
    // ********************************************************
    bus_state_type state_reg;
    logic [7:0]    shift_reg;
    logic [3:0]    bit_cnt_reg;
    logic          in_ack_reg;
    logic          ack_reg;
    logic          bcast_reg;
    logic [7:0]    command_byte_reg;
    logic [7:0]    upper_data_byte_reg;
    logic          ack_now;
    logic          is_local;
    logic          is_bcast;

    // Address byte check; read requests are never acknowledged
    assign is_local = (shift_reg[7:1] == {SLAVE_ADDR_FIXED, addr_pins})
                    & ~shift_reg[0];
    assign is_bcast = (shift_reg[7:1] == BCAST_ADDR) & ~shift_reg[0];

    // Decide whether the byte just shifted in earns an acknowledge
    // Read requests and the high-speed master code both miss here
    always_comb begin
        case (state_reg)
            ST_ADDR: ack_now = is_local | is_bcast;
            ST_CTRL: ack_now = 1'b1;
            ST_HIGH: ack_now = 1'b1;
            ST_LOW:  ack_now = 1'b1;
            default: ack_now = 1'b0;
        endcase
    end

    // Open-drain data line only ever pulls low
    // Kept as a register so every top-level output leaves a flop
    always_ff @(posedge clk_sys) begin
        sda_out <= 1'b0;
    end

    // Bit counter parks at eight through the acknowledge clock
    // Protocol sequencing; start and stop override any byte in flight
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state_reg           <= ST_IDLE;
            shift_reg           <= BYTE_RST;
            bit_cnt_reg         <= '0;
            in_ack_reg          <= 1'b0;
            ack_reg             <= 1'b0;
            bcast_reg           <= 1'b0;
            sda_oe              <= 1'b0;
            command_byte_reg    <= BYTE_RST;
            upper_data_byte_reg <= BYTE_RST;
        end else if (start_cond) begin
            state_reg   <= ST_ADDR;
            bit_cnt_reg <= '0;
            in_ack_reg  <= 1'b0;
            sda_oe      <= 1'b0;
            bcast_reg   <= 1'b0;
        end else if (stop_cond) begin
            state_reg  <= ST_IDLE;
            in_ack_reg <= 1'b0;
            sda_oe     <= 1'b0;
        end else if (state_reg != ST_IDLE) begin
            if (scl_rise && bit_cnt_reg != BITS_PER_BYTE) begin
                shift_reg   <= {shift_reg[6:0], filt_reg[1]};
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            if (scl_fall) begin
                if (bit_cnt_reg == BITS_PER_BYTE && !in_ack_reg) begin
                    in_ack_reg <= 1'b1;
                    ack_reg    <= ack_now;
                    sda_oe     <= ack_now;
                end else if (in_ack_reg) begin
                    // End of acknowledge slot: hand the byte on
                    in_ack_reg  <= 1'b0;
                    sda_oe      <= 1'b0;
                    bit_cnt_reg <= '0;
                    if (!ack_reg) begin
                        state_reg <= ST_IGNORE;
                    end else begin
                        case (state_reg)
                            ST_ADDR: begin
                                bcast_reg <= is_bcast & ~is_local;
                                state_reg <= ST_CTRL;
                            end
                            ST_CTRL: begin
                                command_byte_reg <= shift_reg;
                                state_reg        <= ST_HIGH;
                            end
                            ST_HIGH: begin
                                upper_data_byte_reg <= shift_reg;
                                state_reg           <= ST_LOW;
                            end
                            ST_LOW: begin
                                // Power-down takes just one byte pair
                                state_reg <= command_byte_reg[PD_FLAG_POS]
                                           ? ST_IGNORE : ST_HIGH;
                            end
                            default: state_reg <= ST_IGNORE;
                        endcase
                    end
                end
            end
        end
    end

    // ********************************************************
    // Command decode
    // ********************************************************
    logic [1:0]  upd_mode;
    logic [1:0]  chan_sel;
    logic        pd_flag;
    logic        ext_match;
    logic        commit;
    logic [11:0] new_word;

    assign upd_mode = {command_byte_reg[UPD_MODE_HI_POS],
                       command_byte_reg[UPD_MODE_LO_POS]};
    assign chan_sel = {command_byte_reg[CHAN_SEL_HI_POS],
                       command_byte_reg[CHAN_SEL_LO_POS]};
    assign pd_flag  = command_byte_reg[PD_FLAG_POS];
    // Broadcast address never counts as a pin match; only mode 11
    // acts under it
    assign ext_match = ({command_byte_reg[EXT_ADDR_HI_POS],
                         command_byte_reg[EXT_ADDR_LO_POS]} == ext_pins)
                     & ~bcast_reg;

    // Low byte acknowledged and its clock now falling
    assign commit = scl_fall & in_ack_reg & ack_reg
                  & (state_reg == ST_LOW)
                  & ((upd_mode == MODE_BROADCAST) | ext_match);

    // Power-down keeps only the code, data bits forced to zero
    assign new_word = pd_flag
        ? {upper_data_byte_reg[7:6], {CONV_DATA_W{1'b0}}}
        : {2'b00, upper_data_byte_reg, shift_reg[7:6]};

    // ********************************************************
    // Channel registers
    // ********************************************************
    logic [CHAN_REG_W-1:0] staging_reg [4];
    logic [CHAN_REG_W-1:0] conv_reg    [4];

    genvar ch;
    generate
        for (ch = 0; ch < 4; ch++) begin : g_chan
            logic sel_hit;
            // Channel index as a two-bit select code
            assign sel_hit = (chan_sel == 2'(ch));

            // Staging register of this channel
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    staging_reg[ch] <= CHAN_REG_RST;
                end else if (commit) begin
                    if (upd_mode == MODE_BROADCAST) begin
                        if (chan_sel[1]) begin
                            staging_reg[ch] <= new_word;
                        end
                    end else if (sel_hit) begin
                        staging_reg[ch] <= new_word;
                    end
                end
            end

            // Output register; a commit that writes this register beats a same-cycle strobe
            always_ff @(posedge clk_sys) begin
                if (rst) begin
                    conv_reg[ch] <= CHAN_REG_RST;
                end else if (commit && upd_mode == MODE_DIRECT
                             && sel_hit) begin
                    conv_reg[ch] <= new_word;
                end else if (commit && upd_mode == MODE_SYNC_ALL) begin
                    conv_reg[ch] <= sel_hit
                                  ? new_word : staging_reg[ch];
                end else if (commit && upd_mode == MODE_BROADCAST) begin
                    conv_reg[ch] <= chan_sel[1]
                                  ? new_word
                                  : staging_reg[ch];
                end else if (strobe_rise) begin
                    conv_reg[ch] <= staging_reg[ch];
                end
            end
        end
    endgenerate

    // A channel never written reads back as zero
    // Outputs come straight from the channel flops
    assign output_reg_a = conv_reg[0];
    assign output_reg_b = conv_reg[1];
    assign output_reg_c = conv_reg[2];
    assign output_reg_d = conv_reg[3];

endmodule
